// File: core/mbb_bus_seq.sv
// Multiplexed address/data bus sequencer: bursts, waits and recovery.
// Assumes bus pins resolved outside; core supplies beat-aligned write data.
//
// Contract
// - Writes drive direction, write and data-code high, data until ready low.
// - Write data stays on the bus through recovery and idle until next address.
// - A burst is one address phase and at most four transfers.
// - 32-bit: quad and triple at word bits 00, double at bit2 zero.
// - 16-bit: four-short bursts at A2:A1 zero, two-short at A1 zero.
// - 8-bit: four-byte bursts at A1:A0 zero, two-byte at A0 zero.
// - No burst crosses a 16-byte boundary; straddling requests are split.
// - Requests too wide for one burst become several consecutive bursts.
// - Transfer phase: ready low completes, high inserts a wait.
// - Bursts re-enter transfer after each beat; high adds a data wait.
// - All waits come from one synchronously sampled ready/recover input.
// - One recovery phase by default; low at its end adds another.
// - In recovery low means keep recovering; in transfer low means ready.
// - Recovery: bus floats after read, holds last value after write.
// - Recovery: strobes, last-beat, transceiver enable inactive, lanes all high.
// - Word bits, width, data-code, write and direction freeze in recovery.
// - Idle after read drives read address high bits, word bits, size.
// - Cache-hit requests never move bus or control pins.
// - Address strobe starts each access; last-beat releases at recovery.
// - Last-beat asserted on the final transfer of every access.
// - Lane enables advance per beat on narrow regions, else stay.
module mbb_bus_seq (
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	input  wire logic               req_valid,
	output logic                    req_ready,
	input  mbb_pkg::mbb_req_type    req,
	input  wire logic               wr_valid,
	output logic                    wr_ready,
	input  wire logic [31:0]        wr_data,
	output logic                    rd_valid,
	output logic [31:0]             rd_data,
	input  wire logic               ready_recover_in,
	input  wire logic [31:0]        muxed_addr_data_in,
	output logic [31:0]             muxed_addr_data_out,
	output logic                    muxed_addr_data_oe,
	output logic                    address_strobe_n,
	output logic                    addr_latch,
	output logic                    final_beat_n,
	output logic                    xcvr_on_n,
	output logic                    xcvr_direction,
	output logic                    bus_write,
	output logic                    is_data,
	output logic [3:0]              byte_lane_en_n,
	output logic [1:0]              word_addr_bits,
	output logic [1:0]              bus_width_code
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Bytes per beat for a width code
	function automatic logic [2:0] beat_bytes(input logic [1:0] w);
		if (w == mbb_pkg::WIDTH_8) beat_bytes = 3'h1;
		else if (w == mbb_pkg::WIDTH_16) beat_bytes = 3'h2;
		else beat_bytes = 3'h4;
	endfunction

	// Beats of the next access; zero means a sub-beat single access
	function automatic logic [2:0] plan_beats(input logic [3:0] a,
	                                          input logic [4:0] rem,
	                                          input logic [1:0] w);
		logic [4:0] bb;
		bb = {2'h0, beat_bytes(w)};
		plan_beats = 3'h1;
		if (((a & 4'(bb - 5'h1)) != 4'h0) || (rem < bb)) begin
			plan_beats = 3'h0;
		end else if (((a & 4'(5'(bb << 2) - 5'h1)) == 4'h0)
		             && (rem >= 5'(bb << 2))) begin
			plan_beats = 3'h4;
		end else if ((w == mbb_pkg::WIDTH_32) && (a[3:2] == 2'h0)
		             && (rem >= 5'hC)) begin
			plan_beats = 3'h3;
		end else if (((a & 4'(5'(bb << 1) - 5'h1)) == 4'h0)
		             && (rem >= 5'(bb << 1))) begin
			plan_beats = 3'h2;
		end
	endfunction

	// Active-low lane enables for one beat
	function automatic logic [3:0] lanes(input logic [1:0] w,
	                                     input logic [1:0] a,
	                                     input logic [2:0] nb);
		logic [3:0] on;
		on = 4'h0;
		if (w == mbb_pkg::WIDTH_8) begin
			lanes = {2'h3, a[1], a[0]};
		end else if (w == mbb_pkg::WIDTH_16) begin
			lanes = {~(a[0] | (nb == 3'h2)), 1'b1, a[1], a[0]};
		end else begin
			if (nb == 3'h4) on = 4'hF;
			else if (nb == 3'h2) on = 4'(4'h3 << a);
			else on = 4'(4'h1 << a);
			lanes = ~on;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Ready/recover synchroniser

	logic rr_s1_ff;
	logic rr_s2_ff;
	logic rr_s3_ff;
	logic rdy_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rr_s1_ff <= mbb_pkg::RDY_RST;
			rr_s2_ff <= mbb_pkg::RDY_RST;
			rr_s3_ff <= mbb_pkg::RDY_RST;
			rdy_ff   <= mbb_pkg::RDY_RST;
		end else begin
			rr_s1_ff <= ready_recover_in;
			rr_s2_ff <= rr_s1_ff;
			rr_s3_ff <= rr_s2_ff;
			if (rr_s2_ff == rr_s3_ff) rdy_ff <= rr_s3_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State and request registers

	mbb_pkg::mbb_phase_type state_ff;
	mbb_pkg::mbb_phase_type nxt_state;
	logic        busy_ff;
	logic [31:0] addr_ff;
	logic [4:0]  rem_ff;
	logic        write_ff;
	logic        code_ff;
	logic [1:0]  width_ff;
	logic [2:0]  beats_ff;
	logic [2:0]  step_ff;
	logic        last_wr_ff;
	logic [31:0] mad_ff;
	logic [1:0]  wab_ff;
	logic [3:0]  be_ff;
	logic        wr_pin_ff;
	logic        code_pin_ff;
	logic [1:0]  width_pin_ff;
	logic        rd_valid_ff;
	logic [31:0] rd_data_ff;

	////////////////////////////////////////////////////////////////////////
	// Write FIFO

	logic        fifo_valid;
	logic        fifo_pop;
	logic [31:0] fifo_data;
	logic [2:0]  fifo_count;

	mbb_fifo #(
		.WIDTH (mbb_pkg::DATA_W),
		.DEPTH (mbb_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data),
		.count     (fifo_count)
	);

	////////////////////////////////////////////////////////////////////////
	// Planning and decode

	wire        in_idle   = (state_ff == mbb_pkg::IDLE_PHASE);
	wire        in_addr   = (state_ff == mbb_pkg::ADDRESS_PHASE);
	wire        in_xfer   = (state_ff == mbb_pkg::TRANSFER_PHASE);
	wire        in_recov  = (state_ff == mbb_pkg::RECOVERY_PHASE);
	wire [2:0]  p_beats   = plan_beats(addr_ff[3:0], rem_ff, width_ff);
	wire        p_sub     = (p_beats == 3'h0);
	wire [2:0]  p_cnt     = p_sub ? 3'h1 : p_beats;
	wire [2:0]  p_step    = !p_sub ? beat_bytes(width_ff)
	                      : ((addr_ff[0] || rem_ff == 5'h1) ? 3'h1 : 3'h2);
	wire [1:0]  p_size    = 2'(p_cnt - 3'h1);
	wire        start_ok  = busy_ff && (!write_ff || fifo_count >= p_cnt);
	wire        beat_done = in_xfer && !rdy_ff;
	wire        last_beat = (beats_ff == 3'h1);
	wire [31:0] nxt_addr  = addr_ff + {29'h0, step_ff};
	wire [4:0]  nxt_rem   = rem_ff - {2'h0, step_ff};
	wire        enter_adr = (nxt_state == mbb_pkg::ADDRESS_PHASE) && !in_addr;
	wire        accept    = req_valid && req_ready && !req.cache_hit;

	assign req_ready = !busy_ff;
	assign fifo_pop  = write_ff && (in_addr || (beat_done && !last_beat));

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			mbb_pkg::IDLE_PHASE: begin
				if (start_ok) nxt_state = mbb_pkg::ADDRESS_PHASE;
			end
			mbb_pkg::ADDRESS_PHASE: begin
				nxt_state = mbb_pkg::TRANSFER_PHASE;
			end
			mbb_pkg::TRANSFER_PHASE: begin
				if (beat_done && last_beat) nxt_state = mbb_pkg::RECOVERY_PHASE;
			end
			default: begin
				if (rdy_ff) begin
					nxt_state = start_ok ? mbb_pkg::ADDRESS_PHASE
					                     : mbb_pkg::IDLE_PHASE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencing

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= mbb_pkg::IDLE_PHASE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_ff  <= 1'b0;
			addr_ff  <= '0;
			rem_ff   <= '0;
			write_ff <= 1'b0;
			code_ff  <= 1'b0;
			width_ff <= mbb_pkg::WIDTH_8;
		end else if (accept) begin
			busy_ff  <= 1'b1;
			addr_ff  <= req.addr;
			rem_ff   <= {1'b0, req.nbytes_m1} + 5'h1;
			write_ff <= req.write;
			code_ff  <= req.is_data;
			width_ff <= req.width;
		end else if (beat_done) begin
			addr_ff <= nxt_addr;
			rem_ff  <= nxt_rem;
			if (nxt_rem == 5'h0) busy_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			beats_ff     <= '0;
			step_ff      <= '0;
			last_wr_ff   <= 1'b0;
			wab_ff       <= '0;
			be_ff        <= mbb_pkg::LANES_OFF;
			wr_pin_ff    <= 1'b0;
			code_pin_ff  <= 1'b0;
			width_pin_ff <= mbb_pkg::WIDTH_8;
		end else if (enter_adr) begin
			beats_ff     <= p_cnt;
			step_ff      <= p_step;
			last_wr_ff   <= write_ff;
			wab_ff       <= addr_ff[3:2];
			be_ff        <= lanes(width_ff, addr_ff[1:0], p_step);
			wr_pin_ff    <= write_ff;
			code_pin_ff  <= code_ff || write_ff;
			width_pin_ff <= width_ff;
		end else if (beat_done) begin
			beats_ff <= beats_ff - 3'h1;
			if (!last_beat) begin
				wab_ff <= nxt_addr[3:2];
				be_ff  <= lanes(width_ff, nxt_addr[1:0], step_ff);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mad_ff <= '0;
		end else if (enter_adr) begin
			mad_ff <= {addr_ff[31:2], p_size};
		end else if (fifo_pop) begin
			mad_ff <= fifo_data;
		end else if (beat_done && !write_ff) begin
			mad_ff[3:2] <= addr_ff[3:2];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_valid_ff <= 1'b0;
			rd_data_ff  <= '0;
		end else begin
			rd_valid_ff <= beat_done && !write_ff;
			if (beat_done && !write_ff) rd_data_ff <= muxed_addr_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins

	assign muxed_addr_data_out = mad_ff;
	assign muxed_addr_data_oe  = in_xfer ? write_ff
	                           : (in_recov ? last_wr_ff : 1'b1);
	assign address_strobe_n    = !in_addr;
	assign addr_latch          = in_addr;
	assign xcvr_on_n           = !in_xfer;
	assign final_beat_n        = !(in_xfer && last_beat);
	assign byte_lane_en_n      = (in_recov || in_idle) ? mbb_pkg::LANES_OFF : be_ff;
	assign xcvr_direction      = wr_pin_ff;
	assign bus_write           = wr_pin_ff;
	assign is_data             = code_pin_ff;
	assign word_addr_bits      = wab_ff;
	assign bus_width_code      = width_pin_ff;
	assign rd_valid            = rd_valid_ff;
	assign rd_data             = rd_data_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_final_beat;
		in_xfer && last_beat && !rdy_ff;
	endsequence

	sequence s_recov_exit;
		in_recov && rdy_ff;
	endsequence

	property p_wr_drive;
		in_xfer && write_ff |-> xcvr_direction && bus_write && is_data
		                        && muxed_addr_data_oe;
	endproperty
	a_wr_drive: assert property (p_wr_drive)
		else $error("write transfer pins wrong");

	property p_wr_hold;
		in_recov && last_wr_ff |-> muxed_addr_data_oe && $stable(muxed_addr_data_out);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write data not held in recovery");

	property p_beats_max;
		in_addr |=> in_xfer && beats_ff <= 3'h4 && beats_ff != 3'h0;
	endproperty
	a_beats_max: assert property (p_beats_max)
		else $error("burst beat count out of range");

	property p_align;
		in_addr && beats_ff >= 3'h2 |-> ((addr_ff[3:0]
		    & 4'(5'({2'h0, step_ff} << ((beats_ff > 3'h2) ? 2 : 1)) - 5'h1))
		    == 4'h0);
	endproperty
	a_align: assert property (p_align)
		else $error("burst start misaligned");

	property p_block;
		in_addr |-> ({1'b0, addr_ff[3:0]} + 5'({2'h0, step_ff} * {2'h0, beats_ff}))
		            <= 5'd16;
	endproperty
	a_block: assert property (p_block)
		else $error("burst crosses 16-byte block");

	property p_wait;
		in_xfer && rdy_ff |=> in_xfer && $stable(beats_ff);
	endproperty
	a_wait: assert property (p_wait)
		else $error("transfer advanced without ready");

	property p_end;
		s_final_beat |=> in_recov && final_beat_n && xcvr_on_n;
	endproperty
	a_end: assert property (p_end)
		else $error("access did not end in recovery");

	property p_recov_stay;
		in_recov && !rdy_ff |=> in_recov;
	endproperty
	a_recov_stay: assert property (p_recov_stay)
		else $error("recovery left while held low");

	property p_recov_exit;
		s_recov_exit |=> !in_recov;
	endproperty
	a_recov_exit: assert property (p_recov_exit)
		else $error("extra recovery without request");

	property p_recov_pins;
		in_recov |-> address_strobe_n && !addr_latch && final_beat_n
		             && byte_lane_en_n == 4'hF && $stable(word_addr_bits)
		             && $stable(bus_write) && $stable(bus_width_code);
	endproperty
	a_recov_pins: assert property (p_recov_pins)
		else $error("recovery pin levels wrong");

	property p_hit_quiet;
		in_idle && !busy_ff && req_valid && req.cache_hit |=> in_idle && !busy_ff;
	endproperty
	a_hit_quiet: assert property (p_hit_quiet)
		else $error("cache hit started a bus access");

endmodule // mbb_bus_seq

// File: core/mbb_pkg.sv
// Shared types and constants of the multiplexed-bus burst sequencer.
// Assumes a single core clock domain; pins are resolved by the bench.
package mbb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus width codes on the width pins
	localparam logic [1:0] WIDTH_8  = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Field positions and fixed levels
	localparam int         ADDR_W      = 32;
	localparam int         DATA_W      = 32;
	localparam int         SIZE_LSB    = 0;
	localparam int         WORD_LSB    = 2;
	localparam int         MAX_BEATS   = 4;
	localparam int         BLOCK_BYTES = 16;
	localparam int         FIFO_DEPTH  = 4;
	localparam logic [3:0] LANES_OFF   = 4'hF;
	localparam logic       RDY_RST     = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Bus phases
	typedef enum logic [1:0] {
		IDLE_PHASE,
		ADDRESS_PHASE,
		TRANSFER_PHASE,
		RECOVERY_PHASE
	} mbb_phase_type;

	// Core request: hit requests never reach the pins
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0]  nbytes_m1;
		logic        write;
		logic        is_data;
		logic [1:0]  width;
		logic        cache_hit;
	} mbb_req_type;

endpackage // mbb_pkg

// File: core/mbb_fifo.sv
// Write-data FIFO between core and bus sequencer.
// Assumes one clock; reader drains a word per out_valid and out_ready.
module mbb_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst_b,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic [$clog2(DEPTH+1)-1:0]      count
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0]           mem_ff [DEPTH];
	logic [AW-1:0]              wr_ptr_ff;
	logic [AW-1:0]              rd_ptr_ff;
	logic [$clog2(DEPTH+1)-1:0] cnt_ff;
	wire                        push;
	wire                        pop;

	assign in_ready  = (cnt_ff != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid = (cnt_ff != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_ff[rd_ptr_ff];
	assign count     = cnt_ff;

	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else begin
			if (push) wr_ptr_ff <= inc(wr_ptr_ff);
			if (pop) rd_ptr_ff <= inc(rd_ptr_ff);
			cnt_ff <= cnt_ff + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
		end
	end

endmodule // mbb_fifo

// File: verif/mbb_mem_model.sv
// Far-side memory and ready logic for the multiplexed bus.
// Assumes the bench resolves the bus wire from the design's enable.
module mbb_mem_model (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  wait_n,
	input  wire logic [7:0]  rec_extra,
	input  wire logic        address_strobe_n,
	input  wire logic        xcvr_on_n,
	input  wire logic        xcvr_direction,
	input  wire logic [31:0] bus_out,
	output logic             ready_recover_in,
	output logic [31:0]      mem_drive
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] addr_ff;
	logic [7:0]  cnt_ff;
	logic        xon_ff;
	logic [7:0]  nxt_cnt;
	assign nxt_cnt = (xcvr_on_n != xon_ff) ? 8'h00 : cnt_ff + 8'h01;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_ff <= 16'h0000;
			cnt_ff <= 8'h00;
			xon_ff <= 1'b1;
			ready_recover_in <= 1'b1;
			mem_drive <= 32'h0000_0000;
		end else begin
			xon_ff <= xcvr_on_n;
			cnt_ff <= (nxt_cnt == 8'hFF) ? cnt_ff : nxt_cnt;
			if (!address_strobe_n)
				addr_ff <= bus_out[15:0];
			if (xcvr_on_n)
				ready_recover_in <= (nxt_cnt >= rec_extra);
			else
				ready_recover_in <= (nxt_cnt < wait_n);
			if (!xcvr_on_n && !xcvr_direction)
				mem_drive <= {16'hA5C3, addr_ff};
			else
				mem_drive <= ~mem_drive;
		end
	end
endmodule // mbb_mem_model

// File: verif/mbb_bus_seq_tb.sv
// Self-checking bench of the bus sequencer against the memory model.
// Assumes the package and design files are compiled first.
module mbb_bus_seq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 core_clk = 0;
	logic                 rst_b = 0;
	logic                 req_valid = 0;
	logic                 wr_valid = 0;
	mbb_pkg::mbb_req_type req = '0;
	logic [31:0]          wr_data = 0;
	logic [7:0]           wait_n = 0;
	logic [7:0]           rec_extra = 0;
	logic [31:0]          bus_in, mem_drive, rd_data, out, prev_out;
	logic [31:0]          last_acc = 0;
	logic                 req_ready, wr_ready, rd_valid, rdy, oe, ads_n, latch, fin_n;
	logic                 xon_n, dir, bw, isd, prev_xon, prev_fin;
	logic                 cur_wr = 0;
	logic                 was_wr = 0;
	logic [3:0]           lanes, lane_mask;
	logic [1:0]           wbits, wcode;
	logic [6:0]           prev_frz;
	logic [31:0]          acc_q[$];
	int                   mismatches = 0;
	int                   cmp_count = 0;
	int                   cyc = 0;
	int                   rd_cnt, xfer_len, rec_len;
	always #50 core_clk = ~core_clk;
	assign bus_in = oe ? out : mem_drive;
	mbb_bus_seq dut (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
		.ready_recover_in(rdy), .muxed_addr_data_in(bus_in),
		.muxed_addr_data_out(out), .muxed_addr_data_oe(oe), .address_strobe_n(ads_n),
		.addr_latch(latch), .final_beat_n(fin_n), .xcvr_on_n(xon_n),
		.xcvr_direction(dir), .bus_write(bw), .is_data(isd), .byte_lane_en_n(lanes),
		.word_addr_bits(wbits), .bus_width_code(wcode));
	mbb_mem_model far (.core_clk(core_clk), .rst_b(rst_b), .wait_n(wait_n),
		.rec_extra(rec_extra), .address_strobe_n(ads_n), .xcvr_on_n(xon_n),
		.xcvr_direction(dir), .bus_out(out), .ready_recover_in(rdy),
		.mem_drive(mem_drive));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Bus watcher
	always @(posedge core_clk) begin
		if (rst_b) begin
			cyc++;
			if (cyc > 20000) begin
				mismatches++;
				wrap_up();
			end
			if (!ads_n) begin
				acc_q.push_back(out);
				last_acc = out;
				xfer_len = 0;
				rec_len = 0;
				lane_mask = 4'h0;
			end else if (!xon_n) begin
				xfer_len++;
				lane_mask[lanes[1:0]] = 1'b1;
				was_wr = dir;
				if (cur_wr) chk("wr_pins", 32'h7, {29'h0, dir, bw, isd});
			end else begin
				chk("rec_pins", 32'h3E, {26'h0, lanes, fin_n, latch});
				chk("frozen", {25'h0, prev_frz}, {25'h0, wbits, wcode, dir, bw, isd});
				if (!prev_xon) chk("last_beat", 32'h0, {31'h0, prev_fin});
				if (was_wr) begin
					chk("wr_hold", prev_out, out);
					chk("wr_drive", 32'h1, {31'h0, oe});
				end else if (!prev_xon) begin
					chk("rd_float", 32'h0, {31'h0, oe});
				end else if (oe) begin
					chk("idle_addr", {last_acc[31:4], wbits, last_acc[1:0]}, out);
				end
				if (!was_wr && !oe) rec_len++;
			end
			if (rd_valid) begin
				rd_cnt++;
				chk("rd_data", {16'hA5C3, last_acc[15:0]}, rd_data);
			end
		end
		prev_xon = xon_n;
		prev_fin = fin_n;
		prev_out = out;
		prev_frz = {wbits, wcode, dir, bw, isd};
	end
	////////////////////////////////////////////////////////////////
	task automatic submit(input logic [31:0] a, input logic [3:0] nm1, input logic w,
		input logic hit, input logic [1:0] wd);
		cur_wr = w;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{addr: a, nbytes_m1: nm1, write: w, is_data: 1'b1, width: wd, cache_hit: hit};
		do @(negedge core_clk); while (req_ready !== 1'b1);
		@(posedge core_clk);
		req_valid <= 1'b0;
	endtask
	task automatic wait_done();
		do @(negedge core_clk); while (req_ready !== 1'b1);
		repeat (24) @(posedge core_clk);
	endtask
	task automatic push(input int n, input logic [31:0] b);
		@(posedge core_clk);
		wr_valid <= 1'b1;
		wr_data <= b;
		for (int i = 1; i <= n; i++) begin
			do @(negedge core_clk); while (wr_ready !== 1'b1);
			@(posedge core_clk);
			wr_data <= b + 32'(i);
		end
		wr_valid <= 1'b0;
	endtask
	task automatic rd_case(input logic [31:0] a, input logic [3:0] nm1, input logic [1:0] wd,
		input logic [7:0] wn, input logic [7:0] re, input int nacc, input int beats,
		input logic [31:0] e [4], input logic [3:0] mask, input int rlo, input int rhi);
		wait_n <= wn;
		rec_extra <= re;
		acc_q = {};
		rd_cnt = 0;
		submit(a, nm1, 1'b0, 1'b0, wd);
		wait_done();
		chk("acc_count", 32'(nacc), 32'(acc_q.size()));
		foreach (acc_q[i]) if (i < 4) chk("acc_start", e[i], acc_q[i]);
		chk("beats", 32'(beats), 32'(rd_cnt));
		chk("lanes", {28'h0, mask}, {28'h0, lane_mask});
		chk("rec_len", 32'h1, 32'(rec_len >= rlo && rec_len <= rhi));
		chk("xfer_len", 32'h1, 32'(xfer_len > int'(wn)));
	endtask
	task automatic wr_case();
		wait_n <= 8'h02;
		acc_q = {};
		push(4, 32'h5678_0000);
		@(negedge core_clk);
		chk("fifo_full", 32'h0, {31'h0, wr_ready});
		submit(32'h0000_000A, 4'hB, 1'b1, 1'b0, mbb_pkg::WIDTH_16);
		push(2, 32'hFEED_0004);
		wait_done();
		chk("acc_count", 32'h4, 32'(acc_q.size()));
		foreach (acc_q[i]) if (i < 4) chk("acc_start", i == 0 ? 32'h08 : i == 1 ? 32'h0D : i == 2 ? 32'h11 : 32'h14, acc_q[i]);
	endtask
	task automatic hit_case();
		logic [31:0] o;
		acc_q = {};
		o = out;
		submit(32'h0000_0500, 4'hF, 1'b0, 1'b1, mbb_pkg::WIDTH_32);
		repeat (20) @(posedge core_clk);
		chk("hit_acc", 32'h0, 32'(acc_q.size()));
		chk("hit_bus", o, out);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		rd_case(32'h100, 4'hF, mbb_pkg::WIDTH_32, 0, 0, 1, 4, '{32'h103, 0, 0, 0}, 4'h1, 1, 7);
		rd_case(32'h200, 4'hB, mbb_pkg::WIDTH_32, 0, 0, 1, 3, '{32'h202, 0, 0, 0}, 4'h1, 1, 7);
		rd_case(32'h208, 4'h7, mbb_pkg::WIDTH_32, 0, 0, 1, 2, '{32'h209, 0, 0, 0}, 4'h1, 1, 7);
		rd_case(32'h300, 4'hF, mbb_pkg::WIDTH_8, 0, 0, 4, 16,
			'{32'h303, 32'h307, 32'h30B, 32'h30F}, 4'hF, 1, 7);
		rd_case(32'h400, 4'h3, mbb_pkg::WIDTH_32, 6, 8, 1, 1, '{32'h400, 0, 0, 0}, 4'h1, 9, 16);
		wr_case();
		hit_case();
		wrap_up();
	end
endmodule // mbb_bus_seq_tb
